// >>> shared/tsp_pkg.sv
// constants for the temperature sensor serial port
// assumes a 100 MHz system clock sampling the host serial pins
package tsp_pkg;

  // frame structure, counted in serial clocks
  localparam int          FRAME_CLKS     = 32;
  localparam int          TX_CLKS        = 16;
  localparam int          TX_DRIVEN_BITS = 14;
  localparam int          CMD_BITS       = 8;
  localparam int          WORD_BITS      = 16;
  localparam int          TEMP_BITS      = 11;
  localparam int          ID_BITS        = 11;
  localparam int          CNT_W          = 6;
  localparam int          RXC_W          = 4;

  // frame counter marks, sized for the counter
  localparam logic [5:0]  CNT_ZERO       = 6'h00;
  localparam logic [5:0]  CNT_TX_LAST    = 6'h0F;
  localparam logic [5:0]  CNT_FRAME_LAST = 6'h1F;
  localparam logic [5:0]  CNT_DRIVEN     = 6'h0E;
  localparam logic [3:0]  RXC_FULL       = 4'h8;

  // command decode and word fill fields
  localparam logic [7:0]  CMD_SHUTDOWN   = 8'hFF;
  localparam logic [2:0]  TEMP_FILL      = 3'h7;
  localparam logic [2:0]  ID_FILL        = 3'h0;
  localparam logic [1:0]  UNDRIVEN_BITS  = 2'h0;

  // reset values
  localparam logic        RST_SHUTDOWN   = 1'b0;
  localparam logic [10:0] RST_RESULT     = 11'h000;

  // conversion time
  localparam int          CONV_TIME_MS   = 250;
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          CONV_CYCLES    = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int          TMR_W          = 25;

endpackage : tsp_pkg

// >>> hdl/tsp_sync.sv
// two-flop synchroniser, one chain per bit
// assumes inputs are asynchronous to i_clk
module tsp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // async in, synced out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // first flop feeds only the second
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        meta[g]   <= 1'b0;
        o_sync[g] <= 1'b0;
      end else begin
        meta[g]   <= i_async[g];
        o_sync[g] <= meta[g];
      end
    end
  end

endmodule : tsp_sync

// >>> hdl/tsp_conv_timer.sv
// conversion timer standing in for the modulator cycle
// assumes i_run low clears it; done pulses once per elapsed period
module tsp_conv_timer #(
  parameter int unsigned CYCLES = 25_000_000
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // control and status
  input  wire logic i_run,
  output logic      o_done
);

  logic [tsp_pkg::TMR_W-1:0] cnt;
  logic [tsp_pkg::TMR_W-1:0] next_cnt;
  logic                      next_done;

  // count up while running, restart at end of period
  always_comb begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (!i_run) begin
      next_cnt = '0;
    end else if (cnt == tsp_pkg::TMR_W'(CYCLES - 1)) begin
      next_cnt  = '0;
      next_done = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt    <= '0;
      o_done <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_done <= next_done;
    end
  end

endmodule : tsp_conv_timer

// >>> hdl/tsp_port.sv
// serial slave port of a digital temperature sensor
// assumes host drives chip select and serial clock; data pin is shared
//
// Summary of operation
// R1: reset enters continuous conversion with all state at defaults.
// R2: word before first finished conversion is invalid; flagged by data valid.
// R3: outputs change on falling serial clock, inputs sampled on rising.
// R4: frame is 32 clocks: 16 transmit then 16 receive.
// R5: chip select high keeps data pin undriven.
// R6: host lowers chip select only outside a rising clock edge.
// R7: chip select falling drives the first bit at once.
// R8: after 14 bits the pin is released for rest of transmit.
// R9: chip select may rise mid-transmit; shifting aborts, pin floats.
// R10: conversion running during frame finishes; word refreshed after chip select rises.
// R11: reads any time return last result; word refreshed after read.
// R12: from clock 17 rising edges shift into an 8-bit receive register.
// R13: only the last eight bits before chip select rises are decoded.
// R14: all ones selects shutdown, any zero selects conversion.
// R15: host sends only the listed command bytes.
// R16: host may chain read, shutdown, id read, resume in one burst.
// R17: host waits 250 ms after resuming before trusting temperature.
// R18: bits 15..5 carry 11-bit two's complement temperature, 0.25 C step.
// R19: temperature bits 4..2 are ones, bits 1..0 undriven.
// R20: words leave most significant byte and bit first.
// R21: shutdown reads return the identity word, maker code on top.
// R22: identity bits 4..2 are zero, bits 1..0 undriven.
// R23: low byte ones means shutdown, zeros conversion; upper byte ignored.
// R24: chip select high resets the frame; command applies on its rise.
module tsp_port #(
  parameter int unsigned  CONV_CYCLES = tsp_pkg::CONV_CYCLES,
  parameter logic [10:0]  ID_CODE     = 11'h2A5  // arbitrary identity value
) (
  // clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_N,
  // host serial pins
  input  wire logic        I_SERIAL_CLOCK_PIN,
  input  wire logic        I_CS_N,
  input  wire logic        I_SIO,
  output logic             O_SIO,
  output logic             O_SIO_OE,
  // sensor side
  input  wire logic [10:0] I_TEMP_CODE,
  output logic             O_SHUTDOWN,
  output logic             O_DATA_VALID
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TX,
    ST_RX
  } tsp_state_e;

  // synchronised pins
  logic [2:0]          pins_s;
  logic                sclk_s;
  logic                cs_n_s;
  logic                sio_s;
  logic                sclk_q;
  logic                cs_n_q;
  logic                next_sclk_q;
  logic                next_cs_n_q;
  logic                rise;
  logic                fall;
  logic                cs_fall;
  logic                cs_rise;
  logic                wrap;
  logic                conv_done;

  // frame state
  tsp_state_e          state;
  tsp_state_e          next_state;
  logic [5:0]          clk_cnt;
  logic [5:0]          next_clk_cnt;
  logic [3:0]          rx_cnt;
  logic [3:0]          next_rx_cnt;
  logic [7:0]          rx_sr;
  logic [7:0]          next_rx_sr;
  logic [15:0]         tx_sr;
  logic [15:0]         next_tx_sr;
  logic                sio_oe;
  logic                next_sio_oe;
  logic                reload;
  logic                next_reload;

  // mode and result state
  logic                shutdown;
  logic                next_shutdown;
  logic                valid;
  logic                next_valid;
  logic [10:0]         result;
  logic [10:0]         next_result;
  logic [15:0]         out_word;
  logic [15:0]         next_out_word;

  // helper words
  logic [15:0]         temp_word;
  logic [15:0]         id_word;
  logic [15:0]         load_word;
  logic [7:0]          rx_in;

  // pins cross into the system clock
  tsp_sync #(
    .W (3)
  ) u_sync (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_async ({I_SERIAL_CLOCK_PIN, I_CS_N, I_SIO}),
    .o_sync  (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign sio_s  = pins_s[0];

  // conversion runs only outside shutdown
  tsp_conv_timer #(
    .CYCLES (CONV_CYCLES)
  ) u_timer (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_run   (!shutdown),
    .o_done  (conv_done)
  );

  // edge detection on synced pins
  assign rise    = sclk_s & ~sclk_q;                      // R3
  assign fall    = ~sclk_s & sclk_q;                      // R3
  assign cs_fall = cs_n_q & ~cs_n_s;
  assign cs_rise = ~cs_n_q & cs_n_s;
  assign wrap    = !cs_n_s && rise && state == ST_RX
                   && clk_cnt == tsp_pkg::CNT_FRAME_LAST;  // R16

  // edge flops follow the synced pins
  always_comb begin
    next_sclk_q = sclk_s;
    next_cs_n_q = cs_n_s;
  end

  // reset matches the synchroniser, so no false select fall after reset
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b0;
    end else begin
      sclk_q <= next_sclk_q;
      cs_n_q <= next_cs_n_q;
    end
  end

  // word formats, msb first
  assign temp_word = {result, tsp_pkg::TEMP_FILL, tsp_pkg::UNDRIVEN_BITS};  // R18 R19
  assign id_word   = {ID_CODE, tsp_pkg::ID_FILL, tsp_pkg::UNDRIVEN_BITS};   // R21 R22
  assign load_word = shutdown ? id_word : out_word;                          // R21
  assign rx_in     = {rx_sr[6:0], sio_s};

  // mode, result and output word
  always_comb begin
    next_result   = result;
    next_out_word = out_word;
    next_valid    = valid;
    next_shutdown = shutdown;
    // latch result at end of conversion
    if (conv_done) begin
      next_result = I_TEMP_CODE;                          // R11
      next_valid  = 1'b1;                                 // R2
    end
    // word only refreshed while no frame is open
    if (cs_n_s) begin
      next_out_word = temp_word;                          // R10 R11
    end
    // command at chip select rise or burst wrap
    if (cs_n_s && cs_rise && state == ST_RX && rx_cnt == tsp_pkg::RXC_FULL) begin
      next_shutdown = (rx_sr == tsp_pkg::CMD_SHUTDOWN);   // R14 R23 R24 R13
    end else if (wrap) begin
      next_shutdown = (rx_in == tsp_pkg::CMD_SHUTDOWN);   // R14 R16
    end
    // leaving shutdown needs a fresh conversion
    if (shutdown && !next_shutdown) begin
      next_valid = 1'b0;                                  // R2 R17
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      shutdown <= tsp_pkg::RST_SHUTDOWN;                  // R1
      valid    <= 1'b0;
      result   <= tsp_pkg::RST_RESULT;
      out_word <= '0;
    end else begin
      shutdown <= next_shutdown;
      valid    <= next_valid;
      result   <= next_result;
      out_word <= next_out_word;
    end
  end

  // frame sequencing and receive shifting
  always_comb begin
    next_state   = state;
    next_clk_cnt = clk_cnt;
    next_rx_cnt  = rx_cnt;
    next_rx_sr   = rx_sr;
    if (cs_n_s) begin
      // deselected: frame reset
      next_state   = ST_IDLE;                             // R24 R9
      next_clk_cnt = tsp_pkg::CNT_ZERO;                   // R24
      next_rx_cnt  = '0;
    end else if (cs_fall) begin
      // frame opens with the transmit phase
      next_state   = ST_TX;
      next_clk_cnt = tsp_pkg::CNT_ZERO;
    end else if (rise) begin
      // count serial clocks, receive after the sixteenth
      next_clk_cnt = clk_cnt + 6'h01;                     // R4
      if (state == ST_TX && clk_cnt == tsp_pkg::CNT_TX_LAST) begin
        next_state = ST_RX;                               // R4
      end
      // receive bits on rises of the second half
      if (state == ST_RX) begin
        next_rx_sr = rx_in;                               // R12 R13
        if (rx_cnt != tsp_pkg::RXC_FULL) begin
          next_rx_cnt = rx_cnt + 4'h1;
        end
      end
      if (wrap) begin
        // burst continues into another transmit phase
        next_state   = ST_TX;                             // R16
        next_clk_cnt = tsp_pkg::CNT_ZERO;
        next_rx_cnt  = '0;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      state   <= ST_IDLE;                                 // R1
      clk_cnt <= tsp_pkg::CNT_ZERO;
      rx_cnt  <= '0;
      rx_sr   <= '0;
    end else begin
      state   <= next_state;
      clk_cnt <= next_clk_cnt;
      rx_cnt  <= next_rx_cnt;
      rx_sr   <= next_rx_sr;
    end
  end

  // transmit shifting and data pin drive
  always_comb begin
    next_tx_sr  = tx_sr;
    next_sio_oe = sio_oe;
    next_reload = reload;
    if (cs_n_s) begin
      // deselected: pin released
      next_sio_oe = 1'b0;                                 // R5 R9
      next_reload = 1'b0;
    end else if (cs_fall) begin
      // first bit out as soon as selected
      next_tx_sr  = load_word;                            // R7 R20
      next_sio_oe = 1'b1;                                 // R7
    end else begin
      // burst wrap reloads the word on the next fall
      if (wrap) begin
        next_reload = 1'b1;                               // R16
      end
      // shift on falls, release after the driven bits
      if (fall && state == ST_TX) begin
        if (reload) begin
          next_tx_sr  = load_word;                        // R21
          next_sio_oe = 1'b1;
          next_reload = 1'b0;
        end else if (clk_cnt >= tsp_pkg::CNT_DRIVEN) begin
          next_sio_oe = 1'b0;                             // R8 R19 R22
        end else if (clk_cnt != tsp_pkg::CNT_ZERO) begin
          next_tx_sr = {tx_sr[14:0], 1'b0};               // R3 R20
        end
      end
      // receive phase keeps the pin released
      if (state == ST_RX) begin
        next_sio_oe = 1'b0;                               // R4
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      tx_sr  <= '0;
      sio_oe <= 1'b0;
      reload <= 1'b0;
    end else begin
      tx_sr  <= next_tx_sr;
      sio_oe <= next_sio_oe;
      reload <= next_reload;
    end
  end

  // outputs straight from flops
  assign O_SIO        = tx_sr[15];
  assign O_SIO_OE     = sio_oe;
  assign O_SHUTDOWN   = shutdown;
  assign O_DATA_VALID = valid;

endmodule : tsp_port

// >>> testbench/tsp_port_props.sv
// assertions on the pins of the temperature sensor serial port
// assumes bound into tsp_port; one clock domain, synchronous reset
module tsp_port_props #(
  parameter int unsigned CONV_CYCLES = 50,
  parameter logic [10:0] ID_CODE     = 11'h000
) (
  // clock and reset
  input wire logic        I_MCLK,
  input wire logic        I_RST_N,
  // host pins
  input wire logic        I_SERIAL_CLOCK_PIN,
  input wire logic        I_CS_N,
  input wire logic        I_SIO,
  input wire logic        O_SIO,
  input wire logic        O_SIO_OE,
  // sensor side
  input wire logic [10:0] I_TEMP_CODE,
  input wire logic        O_SHUTDOWN,
  input wire logic        O_DATA_VALID
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  logic       sc_q;
  logic [3:0] since_fall, next_since_fall;
  logic [4:0] nfall, next_nfall;
  int         inv_cnt, next_inv_cnt;
  // serial clock falls in a frame, cycles since last fall, invalid time
  always_comb begin
    next_since_fall = (since_fall == 4'hF) ? since_fall : since_fall + 4'h1;
    next_nfall = I_CS_N ? 5'h00 : nfall;
    if (sc_q && !I_SERIAL_CLOCK_PIN && !I_CS_N) begin
      next_since_fall = 4'h0;
      next_nfall = nfall + 5'h01;
    end
    next_inv_cnt = (O_SHUTDOWN || O_DATA_VALID) ? 0 : inv_cnt + 1;
  end
  // register the helpers
  always_ff @(posedge I_MCLK) begin
    sc_q       <= I_SERIAL_CLOCK_PIN;
    since_fall <= I_RST_N ? next_since_fall : 4'hF;
    nfall      <= I_RST_N ? next_nfall : 5'h00;
    inv_cnt    <= I_RST_N ? next_inv_cnt : 0;
  end
  chk_rst_dflt: assert property (!$past(I_RST_N) |->
    !O_SHUTDOWN && !O_DATA_VALID && !O_SIO_OE) else $error("outputs not at reset value");
  chk_conv_bound: assert property (inv_cnt <= CONV_CYCLES + 4)
    else $error("data valid late");
  chk_out_on_fall: assert property (O_SIO_OE && $past(O_SIO_OE) && $changed(O_SIO)
    |-> since_fall inside {[4'h1:4'h5]}) else $error("data changed off a clock fall");
  chk_cs_float: assert property (I_CS_N [*6] |-> !O_SIO_OE)
    else $error("pin driven while deselected");
  chk_first_bit: assert property ($fell(I_CS_N) |-> ##[2:5] O_SIO_OE)
    else $error("first bit not driven");
  chk_tx_window: assert property (!I_CS_N && since_fall == 4'h6
    |-> O_SIO_OE == (nfall < 5'h0E)) else $error("pin enable wrong in frame");
  chk_mode_hold: assert property (I_CS_N && $past(I_CS_N, 6) |-> $stable(O_SHUTDOWN))
    else $error("mode changed while idle");
  chk_id_msb: assert property ($rose(O_SIO_OE) && O_SHUTDOWN
    |-> O_SIO == ID_CODE[10]) else $error("identity word not shown");
  cover property ($rose(O_SHUTDOWN));
  cover property ($rose(O_DATA_VALID));
  cover property ($rose(I_CS_N) && O_SIO_OE);
endmodule : tsp_port_props

bind tsp_port tsp_port_props #(.CONV_CYCLES(CONV_CYCLES), .ID_CODE(ID_CODE)) u_props (
  .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_SERIAL_CLOCK_PIN(I_SERIAL_CLOCK_PIN),
  .I_CS_N(I_CS_N), .I_SIO(I_SIO), .O_SIO(O_SIO), .O_SIO_OE(O_SIO_OE),
  .I_TEMP_CODE(I_TEMP_CODE), .O_SHUTDOWN(O_SHUTDOWN), .O_DATA_VALID(O_DATA_VALID));

// >>> testbench/tsp_host.sv
// host master model: chip select, serial clock and the shared data wire
// assumes the port's pin value and enable; released wire toggles
module tsp_host (
  // serial pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sio,
  // device drive
  input  wire logic i_dev_sio,
  input  wire logic i_dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic h_en  = 1'b0;
  logic h_val = 1'b0;
  logic flt   = 1'b0;
  // released wire shows a changing pattern
  always #40 flt = ~flt;
  // resolve the shared data wire
  assign o_sio = i_dev_oe ? i_dev_sio : (h_en ? h_val : flt);
  // clock idles low, select idles high
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
  end
  // select changes only with the clock low
  task cs(input logic v);
    #80 o_cs_n = v;
  endtask : cs
  // n clocks of 160 ns; data set after fall, sampled at rise
  task bits(input int n, input logic wr, input logic [15:0] wd,
            output logic [15:0] rd, output logic [15:0] en);
    rd = 16'h0000;
    en = 16'h0000;
    h_en = wr;
    for (int i = 15; i > 15 - n; i--) begin
      h_val = wd[i];
      #80 o_sclk = 1'b1;
      rd[i] = o_sio;
      en[i] = i_dev_oe;
      #80 o_sclk = 1'b0;
    end
    h_en = 1'b0;
  endtask : bits
endmodule : tsp_host

// >>> testbench/tb_top.sv
// self-checking bench for the temperature sensor serial port
// assumes the host model runs frames; conversion shortened to 50 cycles
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [10:0] ID = 11'h4C3;  // arbitrary identity value
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sclk, cs_n, sio, dev_o, dev_oe, shut, valid, s;
  logic [10:0] temp = 11'h258;
  logic [15:0] rd, en;
  logic [7:0]  cmds [10] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F,
                             8'h1F, 8'h3F, 8'h7F, 8'hFF, 8'h00};
  int          errors = 0;
  int          n_checks = 0;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  tsp_port #(.CONV_CYCLES(50), .ID_CODE(ID)) uut (
    .I_MCLK(mclk), .I_RST_N(rst_n), .I_SERIAL_CLOCK_PIN(sclk), .I_CS_N(cs_n),
    .I_SIO(sio), .O_SIO(dev_o), .O_SIO_OE(dev_oe), .I_TEMP_CODE(temp),
    .O_SHUTDOWN(shut), .O_DATA_VALID(valid));
  tsp_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sio(sio), .i_dev_sio(dev_o),
                 .i_dev_oe(dev_oe));
  // temperature word: code, three ones, two undriven
  function automatic logic [15:0] tw(input logic [10:0] c);
    return {c, 3'h7, 2'h0};
  endfunction : tw
  // compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // report and end the run
  task summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // bounded wait for a finished conversion
  task wait_valid;
    int k;
    for (k = 0; k < 200 && valid !== 1'b1; k++) @(posedge mclk);
    if (k == 200) begin
      errors++;
      $display("Error %0t: data valid never rose", $time);
      summarize();
    end
  endtask : wait_valid
  // one frame: read word, change code, write nw command bits
  task frame(input logic [10:0] nt, input int nw, input logic [15:0] cmd,
             input logic [15:0] exp);
    #1 host.cs(1'b0);
    @(posedge mclk);
    #1 temp = nt;
    host.bits(16, 1'b0, 16'h0000, rd, en);
    chk({rd[15:2], 2'h0}, exp);
    chk(en, 16'hFFFC);
    if (nw > 0) host.bits(nw, 1'b1, cmd, rd, en);
    host.cs(1'b1);
    repeat (8) @(posedge mclk);
  endtask : frame
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk({shut, valid, dev_oe}, 16'h0000);
    wait_valid();
    frame(11'h724, 16, 16'h0000, tw(11'h258));
    frame(11'h724, 16, 16'h0000, tw(11'h724));
    #1 host.cs(1'b0);
    host.bits(5, 1'b0, 16'h0000, rd, en);
    host.cs(1'b1);
    repeat (6) @(posedge mclk);
    chk({rd[15:11], dev_oe}, 16'h0038);
    s = 1'b0;
    foreach (cmds[i]) begin
      frame(11'h724, 16, {8'hA5, cmds[i]}, s ? {ID, 5'h00} : tw(11'h724));
      s = (cmds[i] === 8'hFF);
      chk(shut, s);
      if (!s) wait_valid();
    end
    frame(11'h724, 16, 16'h00FF, tw(11'h724));
    chk(shut, 1'b1);
    frame(11'h724, 7, 16'h0000, {ID, 5'h00});
    chk(shut, 1'b1);
    frame(11'h724, 16, 16'hFF00, {ID, 5'h00});
    chk(shut, 1'b0);
    wait_valid();
    #1 host.cs(1'b0);
    host.bits(16, 1'b0, 16'h0000, rd, en);
    host.bits(16, 1'b1, 16'hFFFF, rd, en);
    host.bits(16, 1'b0, 16'h0000, rd, en);
    chk({shut, rd[15:2]}, {1'b1, ID, 3'h0});
    host.bits(8, 1'b1, 16'h0000, rd, en);
    host.cs(1'b1);
    repeat (8) @(posedge mclk);
    chk({shut, valid}, 16'h0000);
    wait_valid();
    frame(11'h258, 0, 16'h0000, tw(11'h724));
    // reset again in mid-run, with data valid high
    @(posedge mclk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk({shut, valid, dev_oe}, 16'h0000);
    summarize();
  end
endmodule : tb_top
